// file: hw/ahb_sram_flash_memory_controller.sv
/*
  AHB-Lite slave giving one master access to external NVM and SRAM over three slots.
  Assumes a single master, tri-state buffering above this block, and one clock.
*/
`timescale 1ns/10ps
module ahb_sram_flash_memory_controller
  import memctl_pkg::*;
#(
  parameter bit         P_RAM_SYNC    = RAM_SYNC_DEF,
  parameter bit         P_NVM_16BIT   = NVM_16BIT_DEF,
  parameter logic [1:0] P_NVM_RD_WAIT = NVM_RD_WAIT_DEF,
  parameter logic [1:0] P_NVM_WR_WAIT = NVM_WR_WAIT_DEF,
  parameter logic [1:0] P_RAM_RD_WAIT = RAM_RD_WAIT_DEF,
  parameter logic [1:0] P_RAM_WR_WAIT = RAM_WR_WAIT_DEF
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_alias_sel = 1'b0,
  input  wire ahb_req_s          i_alias_region_port,
  input  wire ahb_req_s          i_nvm_region_port,
  input  wire ahb_req_s          i_ram_region_port,
  output ahb_rsp_s               o_alias_region_rsp,
  output ahb_rsp_s               o_nvm_region_rsp,
  output ahb_rsp_s               o_ram_region_rsp,
  input  wire logic [31:0]       i_ext_read_bus,
  output logic                   o_nvm_select_n,
  output logic                   o_nvm_output_en_n,
  output logic                   o_nvm_write_en_n,
  output logic                   o_ram_select_n,
  output logic                   o_ram_output_en_n,
  output logic                   o_ram_write_en_n,
  output logic [3:0]             o_ram_lane_en_n,
  output logic                   o_combined_read_strobe_n,
  output logic                   o_combined_write_strobe_n,
  output logic [MEM_ADDR_W-1:0]  o_ext_address_out,
  output logic                   o_ext_drive_en_n,
  output logic [31:0]            o_ext_write_bus
);

  function automatic logic [3:0] lane_mask(input logic [2:0] sz, input logic [1:0] a);
    case (sz)
      SIZE_BYTE: lane_mask = 4'h1 << a;
      SIZE_HALF: lane_mask = a[1] ? 4'hC : 4'h3;
      default:   lane_mask = 4'hF;
    endcase
  endfunction : lane_mask

  function automatic mem_ctl_s ctl_idle();
    ctl_idle = '{NEGATE_N, NEGATE_N, NEGATE_N, NEGATE_N, NEGATE_N, NEGATE_N,
                 LANES_OFF_N, NEGATE_N, NEGATE_N, NEGATE_N};
  endfunction : ctl_idle

  ahb_req_s [PORTS-1:0]  req;
  logic [PORTS-1:0]      start;
  logic                  any_start;
  logic [1:0]            start_idx;
  logic                  timer_zero;
  logic                  timer_load;
  logic [1:0]            timer_val;

  mc_state_e             state,   next_state;
  logic                  tgt_ram, next_tgt_ram;
  logic [1:0]            port,    next_port;
  logic [2:0]            size,    next_size;
  logic                  half,    next_half;
  logic [MEM_ADDR_W-1:0] addr,    next_addr;
  logic [31:0]           wbuf,    next_wbuf;
  logic [31:0]           wbus,    next_wbus;
  ahb_rsp_s              rsp,     next_rsp;
  mem_ctl_s              ctl,     next_ctl;
  logic                  nvm_split;
  logic [1:0]            rd_wait, wr_wait;

  assign req = {i_ram_region_port, i_nvm_region_port, i_alias_region_port};

  generate
    for (genvar g = 0; g < PORTS; g++) begin : g_slot
      mc_slot_decode u_dec (
        .i_req   (req[g]),
        .o_start (start[g])
      );
    end
  endgenerate

  mc_wait_timer u_timer (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_load    (timer_load),
    .i_count   (timer_val),
    .o_zero    (timer_zero)
  );

  assign any_start = |start;

  always_comb begin
    start_idx = 2'(PORT_ALIAS);
    for (int k = PORTS - 1; k >= 0; k--) begin
      if (start[k]) begin
        start_idx = 2'(k);
      end
    end
  end

  // Synchronous RAM uses fixed timing; wait options apply only when asynchronous
  always_comb begin
    rd_wait = P_NVM_RD_WAIT;
    wr_wait = P_NVM_WR_WAIT;
    if (tgt_ram) begin
      rd_wait = P_RAM_SYNC ? SYNC_RAM_RD_WAIT : P_RAM_RD_WAIT;
      wr_wait = P_RAM_SYNC ? SYNC_RAM_WR_WAIT : P_RAM_WR_WAIT;
    end
  end

  // A 16-bit NVM word is done as two halfword accesses, low half first
  assign nvm_split = P_NVM_16BIT && !tgt_ram && (size == SIZE_WORD);

  always_comb begin
    next_state   = state;
    next_tgt_ram = tgt_ram;
    next_port    = port;
    next_size    = size;
    next_half    = half;
    next_addr    = addr;
    next_wbuf    = wbuf;
    next_wbus    = wbus;
    next_rsp     = rsp;
    next_ctl     = ctl;
    timer_load   = 1'b0;
    timer_val    = 2'h0;
    case (state)
      ST_IDLE: begin
        if (any_start) begin
          next_port    = start_idx;
          next_tgt_ram = (start_idx == 2'(PORT_RAM)) ||
                         ((start_idx == 2'(PORT_ALIAS)) && i_alias_sel);
          next_size    = req[start_idx].size;
          next_addr    = req[start_idx].addr[MEM_ADDR_W-1:0];
          next_half    = 1'b0;
          next_rsp.readyout = 1'b0;
          next_ctl.nvm_select_n = next_tgt_ram;
          next_ctl.ram_select_n = !next_tgt_ram;
          if (next_tgt_ram) begin
            next_ctl.ram_lane_en_n = ~lane_mask(next_size,
                                                next_addr[1:0]);
          end
          if (req[start_idx].write) begin
            next_state = ST_WSETUP;
          end else begin
            next_state = ST_READ;
            next_ctl.nvm_output_en_n = next_tgt_ram;
            next_ctl.ram_output_en_n = !next_tgt_ram;
            timer_load = 1'b1;
            timer_val  = (next_tgt_ram) ? (P_RAM_SYNC ? SYNC_RAM_RD_WAIT : P_RAM_RD_WAIT)
                                        : P_NVM_RD_WAIT;
          end
        end
      end
      ST_READ: begin
        if (timer_zero) begin
          if (nvm_split && !half) begin
            next_half = 1'b1;
            next_rsp.rdata[15:0] = i_ext_read_bus[15:0];
            next_addr[1] = 1'b1;
            timer_load = 1'b1;
            timer_val  = rd_wait;
          end else begin
            if (nvm_split) begin
              next_rsp.rdata = {i_ext_read_bus[15:0], rsp.rdata[15:0]};
            end else if (P_NVM_16BIT && !tgt_ram) begin
              next_rsp.rdata = {2{i_ext_read_bus[15:0]}};
            end else begin
              next_rsp.rdata = i_ext_read_bus;
            end
            next_rsp.readyout = 1'b1;
            next_ctl   = ctl_idle();
            next_state = ST_IDLE;
          end
        end
      end
      ST_WSETUP: begin
        // Write data arrives in the AHB data phase, one cycle after the address
        next_wbuf = req[port].wdata;
        if (P_NVM_16BIT && !tgt_ram) begin
          next_wbus = {16'h0, (addr[1] && !nvm_split) ? next_wbuf[31:16] : next_wbuf[15:0]};
        end else begin
          next_wbus = next_wbuf;
        end
        next_ctl.ext_drive_en_n = ASSERT_N;
        next_ctl.nvm_write_en_n = tgt_ram;
        next_ctl.ram_write_en_n = !tgt_ram;
        timer_load = 1'b1;
        timer_val  = wr_wait - 2'h1;
        next_state = ST_WRITE;
      end
      ST_WRITE: begin
        if (timer_zero) begin
          next_ctl.nvm_write_en_n = NEGATE_N;
          next_ctl.ram_write_en_n = NEGATE_N;
          next_ctl.ext_drive_en_n = NEGATE_N;
          if (nvm_split && !half) begin
            next_state = ST_GAP;
          end else begin
            next_rsp.readyout = 1'b1;
            next_ctl   = ctl_idle();
            next_state = ST_IDLE;
          end
        end
      end
      ST_GAP: begin
        // One cycle with write enable high separates the two NVM halves
        next_half    = 1'b1;
        next_addr[1] = 1'b1;
        next_wbus    = {16'h0, wbuf[31:16]};
        next_ctl.nvm_write_en_n = ASSERT_N;
        next_ctl.ext_drive_en_n = ASSERT_N;
        timer_load = 1'b1;
        timer_val  = wr_wait - 2'h1;
        next_state = ST_WRITE;
      end
      default: begin
        next_ctl   = ctl_idle();
        next_state = ST_IDLE;
      end
    endcase
    next_ctl.combined_read_strobe_n  = next_ctl.nvm_output_en_n &
                                       next_ctl.ram_output_en_n;
    next_ctl.combined_write_strobe_n = next_ctl.nvm_write_en_n &
                                       next_ctl.ram_write_en_n;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state   <= ST_IDLE;
      tgt_ram <= 1'b0;
      port    <= 2'h0;
      size    <= SIZE_BYTE;
      half    <= 1'b0;
      addr    <= '0;
      wbuf    <= 32'h0;
      wbus    <= 32'h0;
      rsp     <= '{1'b1, RESP_OKAY, RDATA_RST};
      ctl     <= '{NEGATE_N, NEGATE_N, NEGATE_N, NEGATE_N, NEGATE_N, NEGATE_N,
                   LANES_OFF_N, NEGATE_N, NEGATE_N, NEGATE_N};
    end else begin
      state   <= next_state;
      tgt_ram <= next_tgt_ram;
      port    <= next_port;
      size    <= next_size;
      half    <= next_half;
      addr    <= next_addr;
      wbuf    <= next_wbuf;
      wbus    <= next_wbus;
      rsp     <= next_rsp;
      ctl     <= next_ctl;
    end
  end

  // One master means one answer shared by all three slots; separate pins, no tri-state
  assign o_alias_region_rsp        = rsp;
  assign o_nvm_region_rsp          = rsp;
  assign o_ram_region_rsp          = rsp;
  assign o_nvm_select_n            = ctl.nvm_select_n;
  assign o_nvm_output_en_n         = ctl.nvm_output_en_n;
  assign o_nvm_write_en_n          = ctl.nvm_write_en_n;
  assign o_ram_select_n            = ctl.ram_select_n;
  assign o_ram_output_en_n         = ctl.ram_output_en_n;
  assign o_ram_write_en_n          = ctl.ram_write_en_n;
  assign o_ram_lane_en_n           = ctl.ram_lane_en_n;
  assign o_combined_read_strobe_n  = ctl.combined_read_strobe_n;
  assign o_combined_write_strobe_n = ctl.combined_write_strobe_n;
  assign o_ext_drive_en_n          = ctl.ext_drive_en_n;
  assign o_ext_address_out         = addr;
  assign o_ext_write_bus           = wbus;

  // Checking helpers: length of the current low pulse of each NVM and RAM output enable and write enable
  logic [3:0] noe_len, nwe_len, roe_len, rwe_len;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      noe_len <= 4'h0;
      nwe_len <= 4'h0;
      roe_len <= 4'h0;
      rwe_len <= 4'h0;
    end else begin
      noe_len <= o_nvm_output_en_n ? 4'h0 : noe_len + 4'h1;
      nwe_len <= o_nvm_write_en_n ? 4'h0 : nwe_len + 4'h1;
      roe_len <= o_ram_output_en_n ? 4'h0 : roe_len + 4'h1;
      rwe_len <= o_ram_write_en_n ? 4'h0 : rwe_len + 4'h1;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  AST_ALIAS_TARGET: assert property (start[PORT_ALIAS] && state == ST_IDLE |=>
    (o_nvm_select_n == $past(i_alias_sel)) && (o_ram_select_n == !$past(i_alias_sel)))
    else $error("alias slot reached the wrong memory");
  AST_RAM_SLOT_SEL: assert property (start == 3'h4 && state == ST_IDLE |=>
    !o_ram_select_n && o_nvm_select_n) else $error("RAM slot did not select RAM");
  AST_COMB_READ: assert property (o_combined_read_strobe_n ==
    (o_nvm_output_en_n & o_ram_output_en_n)) else $error("combined read strobe wrong");
  AST_COMB_WRITE: assert property (o_combined_write_strobe_n ==
    (o_nvm_write_en_n & o_ram_write_en_n)) else $error("combined write strobe wrong");
  AST_DRIVE_EN: assert property (o_ext_drive_en_n ==
    (o_nvm_write_en_n & o_ram_write_en_n)) else $error("drive enable not tied to write");
  AST_NVM_RD_WAIT: assert property (!P_NVM_16BIT && $rose(o_nvm_output_en_n) |->
    noe_len == 4'(P_NVM_RD_WAIT) + 4'h1) else $error("NVM read wait count wrong");
  AST_NVM_WR_WAIT: assert property ($rose(o_nvm_write_en_n) |->
    nwe_len == 4'(P_NVM_WR_WAIT)) else $error("NVM write wait count wrong");
  AST_RAM_RD_WAIT: assert property ($rose(o_ram_output_en_n) |-> roe_len ==
    4'(P_RAM_SYNC ? SYNC_RAM_RD_WAIT : P_RAM_RD_WAIT) + 4'h1)
    else $error("RAM read wait count wrong");
  AST_RAM_WR_WAIT: assert property ($rose(o_ram_write_en_n) |-> rwe_len ==
    4'(P_RAM_SYNC ? SYNC_RAM_WR_WAIT : P_RAM_WR_WAIT)) else $error("RAM write wait count wrong");
  AST_READY_STRETCH: assert property (any_start && state == ST_IDLE |=>
    !rsp.readyout ##[1:16] rsp.readyout) else $error("ready not stretched then raised");
  AST_LANES: assert property (start == 3'h4 && state == ST_IDLE |=>
    o_ram_lane_en_n == ~lane_mask($past(i_ram_region_port.size),
                                  $past(i_ram_region_port.addr[1:0])))
    else $error("lane enables do not match size and address");
  AST_IDLE_NEGATED: assert property (state == ST_IDLE |->
    o_nvm_select_n && o_ram_select_n && o_ram_lane_en_n == LANES_OFF_N && o_ext_drive_en_n)
    else $error("strobe asserted while idle");

  COV_NVM_READ:  cover property ($rose(o_nvm_output_en_n));
  COV_RAM_WRITE: cover property ($rose(o_ram_write_en_n));
  COV_ALIAS_RAM: cover property (start[PORT_ALIAS] && i_alias_sel && state == ST_IDLE);
  COV_NVM_GAP:   cover property (state == ST_GAP);
endmodule : ahb_sram_flash_memory_controller

// file: hw/memctl_pkg.sv
/*
  Shared constants and carrier types for the external SRAM/NVM memory controller.
  Assumes a single AHB-Lite master and one synchronous clock domain.
*/
package memctl_pkg;
  localparam int         PORTS       = 3;
  localparam int         PORT_ALIAS  = 0;
  localparam int         PORT_NVM    = 1;
  localparam int         PORT_RAM    = 2;
  localparam int         MEM_ADDR_W  = 28;
  localparam int         LANES       = 4;
  localparam logic [2:0] SIZE_BYTE   = 3'h0;
  localparam logic [2:0] SIZE_HALF   = 3'h1;
  localparam logic [2:0] SIZE_WORD   = 3'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic       ASSERT_N    = 1'b0;
  localparam logic       NEGATE_N    = 1'b1;
  localparam logic [3:0] LANES_OFF_N = 4'hF;
  localparam logic [31:0] RDATA_RST  = 32'h0;
  // Build-time option defaults, then the fixed synchronous RAM wait counts
  localparam bit         RAM_SYNC_DEF     = 1'b0;
  localparam bit         NVM_16BIT_DEF    = 1'b0;
  localparam logic [1:0] NVM_RD_WAIT_DEF  = 2'h1;
  localparam logic [1:0] NVM_WR_WAIT_DEF  = 2'h1;
  localparam logic [1:0] RAM_RD_WAIT_DEF  = 2'h1;
  localparam logic [1:0] RAM_WR_WAIT_DEF  = 2'h1;
  localparam logic [1:0] SYNC_RAM_RD_WAIT = 2'h1;
  localparam logic [1:0] SYNC_RAM_WR_WAIT = 2'h1;

  typedef struct packed {
    logic        sel;
    logic [1:0]  trans;
    logic        write;
    logic [2:0]  size;
    logic [31:0] addr;
    logic        ready;
    logic [31:0] wdata;
  } ahb_req_s;

  typedef struct packed {
    logic        readyout;
    logic [1:0]  resp;
    logic [31:0] rdata;
  } ahb_rsp_s;

  typedef struct packed {
    logic       nvm_select_n;
    logic       nvm_output_en_n;
    logic       nvm_write_en_n;
    logic       ram_select_n;
    logic       ram_output_en_n;
    logic       ram_write_en_n;
    logic [3:0] ram_lane_en_n;
    logic       combined_read_strobe_n;
    logic       combined_write_strobe_n;
    logic       ext_drive_en_n;
  } mem_ctl_s;

  typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_WSETUP, ST_WRITE, ST_GAP} mc_state_e;
endpackage : memctl_pkg

// file: hw/mc_slot_decode.sv
/*
  Recognises a valid AHB address phase on one slave slot.
  Assumes HREADY from the fabric is the common ready seen by all slots.
*/
`timescale 1ns/10ps
module mc_slot_decode
  import memctl_pkg::*;
(
  input  wire ahb_req_s i_req,
  output logic          o_start
);
  // NONSEQ or SEQ while selected and the bus is ready
  assign o_start = i_req.sel & i_req.trans[1] & i_req.ready;
endmodule : mc_slot_decode

// file: hw/mc_wait_timer.sv
/*
  Down counter that times wait states of one memory access.
  Assumes loads come from the controller state machine only.
*/
`timescale 1ns/10ps
module mc_wait_timer
  import memctl_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_load,
  input  wire logic [1:0] i_count,
  output logic            o_zero
);
  logic [1:0] cnt;
  logic [1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (i_load) begin
      next_cnt = i_count;
    end else if (cnt != 2'h0) begin
      next_cnt = cnt - 2'h1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= 2'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign o_zero = (cnt == 2'h0);
endmodule : mc_wait_timer

// file: dv/mem_partner.sv
/*
  Behavioural external NVM and RAM devices, sixteen words each.
  Assumes a 32-bit NVM bus and strobes registered by the controller.
*/
`timescale 1ns/10ps
module mem_partner
  import memctl_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire mem_ctl_s              i_ctl,
  input  wire logic [MEM_ADDR_W-1:0] i_addr,
  input  wire logic [31:0]           i_wbus,
  output logic [31:0]                o_rbus
);
  logic [31:0] nvm [16];
  logic [31:0] ram [16];
  logic [31:0] last = 32'h0;
  logic [3:0]  idx;
  logic        rd_nvm;
  logic        rd_ram;
  logic        wr_nvm;
  logic        wr_ram;

  assign idx    = i_addr[5:2];
  assign rd_nvm = !i_ctl.nvm_select_n && !i_ctl.nvm_output_en_n;
  assign rd_ram = !i_ctl.ram_select_n && !i_ctl.ram_output_en_n;
  // Write data is only taken while the controller enables its drivers
  assign wr_nvm = !i_ctl.ext_drive_en_n && !i_ctl.nvm_select_n && !i_ctl.nvm_write_en_n;
  assign wr_ram = !i_ctl.ext_drive_en_n && !i_ctl.ram_select_n && !i_ctl.ram_write_en_n;
  // A released bus shows the inverse of its last value, never a stale copy
  assign o_rbus = rd_nvm ? nvm[idx] : (rd_ram ? ram[idx] : ~last);

  always @(posedge i_ref_clk) begin
    if (rd_nvm || rd_ram) begin
      last <= o_rbus;
    end
    if (wr_nvm) begin
      nvm[idx] <= i_wbus;
    end
    for (int k = 0; k < LANES; k++) begin
      if (wr_ram && !i_ctl.ram_lane_en_n[k]) begin
        ram[idx][8*k +: 8] <= i_wbus[8*k +: 8];
      end
    end
  end
endmodule : mem_partner

// file: dv/ahb_sram_flash_memory_controller_tb.sv
/*
  Self-checking bench: one AHB-Lite master over three slots, memory model behind.
  Assumes default build options and the wait-state defaults of the package.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got %0h exp %0h", $time, (g), (e)); end end
module ahb_sram_flash_memory_controller_tb;
  import memctl_pkg::*;
  logic                  clk = 1'b0;
  logic                  resetn = 1'b0;
  logic                  alias_sel = 1'b0;
  logic [2:0]            sel = 3'h0;
  logic [1:0]            trans = 2'h0;
  logic                  write = 1'b0;
  logic [2:0]            size = 3'h0;
  logic [31:0]           addr = 32'h0;
  logic [31:0]           wdata = 32'h0;
  ahb_req_s              req [PORTS];
  wire ahb_rsp_s         rsp [PORTS];
  wire mem_ctl_s         ctl;
  logic [31:0]           rbus;
  logic [31:0]           wbus;
  logic [MEM_ADDR_W-1:0] maddr;
  logic [31:0]           ref_mem [2][16];
  logic [3:0]            lanes_seen;
  logic [27:0]           addr_seen;
  logic [31:0]           wbus_seen;
  logic [31:0]           rd;
  int                    l_cnt;
  int                    sel_cnt [2];
  int                    oe_cnt [2];
  int                    we_cnt [2];
  int                    failures = 0;
  int                    checks_done = 0;
  int                    seed = 96;

  always #2 clk = ~clk;
  for (genvar p = 0; p < PORTS; p++) begin : g_req
    assign req[p] = '{sel[p], trans, write, size, addr, rsp[0].readyout, wdata};
  end

  ahb_sram_flash_memory_controller DUT (
    .i_ref_clk(clk), .i_resetn(resetn), .i_alias_sel(alias_sel),
    .i_alias_region_port(req[PORT_ALIAS]), .i_nvm_region_port(req[PORT_NVM]),
    .i_ram_region_port(req[PORT_RAM]), .o_alias_region_rsp(rsp[PORT_ALIAS]),
    .o_nvm_region_rsp(rsp[PORT_NVM]), .o_ram_region_rsp(rsp[PORT_RAM]),
    .i_ext_read_bus(rbus), .o_nvm_select_n(ctl.nvm_select_n),
    .o_nvm_output_en_n(ctl.nvm_output_en_n), .o_nvm_write_en_n(ctl.nvm_write_en_n),
    .o_ram_select_n(ctl.ram_select_n), .o_ram_output_en_n(ctl.ram_output_en_n),
    .o_ram_write_en_n(ctl.ram_write_en_n), .o_ram_lane_en_n(ctl.ram_lane_en_n),
    .o_combined_read_strobe_n(ctl.combined_read_strobe_n),
    .o_combined_write_strobe_n(ctl.combined_write_strobe_n),
    .o_ext_address_out(maddr), .o_ext_drive_en_n(ctl.ext_drive_en_n),
    .o_ext_write_bus(wbus));

  mem_partner u_mem (.i_ref_clk(clk), .i_ctl(ctl), .i_addr(maddr), .i_wbus(wbus),
                     .o_rbus(rbus));

  function automatic logic [3:0] lanes_exp(input logic [2:0] sz, input logic [1:0] a);
    if (sz == SIZE_BYTE) return ~(4'h1 << a);
    if (sz == SIZE_HALF) return a[1] ? 4'h3 : 4'hC;
    return 4'h0;
  endfunction : lanes_exp

  function automatic logic [31:0] mask32(input logic [3:0] ln);
    for (int k = 0; k < 4; k++) begin
      mask32[8*k +: 8] = {8{!ln[k]}};
    end
  endfunction : mask32

  // One AHB transfer; counts strobe cycles at each falling edge until ready returns
  task automatic xfer(input int p, input logic w, input logic [2:0] sz, input logic [31:0] a,
                      input logic [31:0] wd);
    @(posedge clk);
    sel[p] <= 1'b1;
    trans  <= 2'h2;
    write  <= w;
    size   <= sz;
    addr   <= a;
    @(posedge clk);
    sel    <= 3'h0;
    trans  <= 2'h0;
    wdata  <= wd;
    l_cnt = 0;
    sel_cnt = '{0, 0};
    oe_cnt = '{0, 0};
    we_cnt = '{0, 0};
    do begin
      @(negedge clk);
      l_cnt++;
      sel_cnt[0] += int'(!ctl.nvm_select_n);
      sel_cnt[1] += int'(!ctl.ram_select_n);
      oe_cnt[0] += int'(!ctl.nvm_output_en_n);
      oe_cnt[1] += int'(!ctl.ram_output_en_n);
      we_cnt[0] += int'(!ctl.nvm_write_en_n);
      we_cnt[1] += int'(!ctl.ram_write_en_n);
      if (!ctl.ram_select_n) lanes_seen = ctl.ram_lane_en_n;
      if (!(ctl.nvm_select_n && ctl.ram_select_n)) addr_seen = maddr;
      if (!ctl.ext_drive_en_n) wbus_seen = wbus;
    end while (rsp[0].readyout !== 1'b1 && l_cnt < 20);
    rd = rsp[p].rdata;
  endtask : xfer

  task automatic run(input int p, input logic w, input logic [2:0] sz, input logic [5:0] off);
    logic [31:0] a;
    logic [31:0] wd;
    logic [31:0] mask;
    int          m;
    int          wt;
    a = {4'(p), 22'h0, off};
    wd = $random(seed);
    xfer(p, w, sz, a, wd);
    m = (p == PORT_RAM || (p == PORT_ALIAS && alias_sel)) ? 1 : 0;
    wt = m ? (w ? RAM_WR_WAIT_DEF : RAM_RD_WAIT_DEF) : (w ? NVM_WR_WAIT_DEF : NVM_RD_WAIT_DEF);
    mask = m ? mask32(lanes_exp(sz, off[1:0])) : 32'hFFFF_FFFF;
    // Ready stays low one cycle longer than the strobe waits, for reads and writes alike
    `CHK(l_cnt - 1, wt + 1)
    `CHK(sel_cnt[m], l_cnt - 1)
    `CHK(sel_cnt[1-m] + oe_cnt[1-m] + we_cnt[1-m], 0)
    `CHK(oe_cnt[m], w ? 0 : wt + 1)
    `CHK(we_cnt[m], w ? wt : 0)
    `CHK(addr_seen, a[27:0])
    if (m) `CHK(lanes_seen, lanes_exp(sz, off[1:0]))
    if (w) begin
      `CHK(wbus_seen, wd)
      ref_mem[m][off[5:2]] = (ref_mem[m][off[5:2]] & ~mask) | (wd & mask);
    end else `CHK(rd & mask, ref_mem[m][off[5:2]] & mask)
  endtask : run

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  always @(negedge clk) begin
    if (resetn) begin
      `CHK(ctl.combined_read_strobe_n, ctl.nvm_output_en_n & ctl.ram_output_en_n)
      `CHK(ctl.combined_write_strobe_n, ctl.nvm_write_en_n & ctl.ram_write_en_n)
      `CHK(ctl.ext_drive_en_n, ctl.combined_write_strobe_n)
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end

  initial begin
    int p;
    logic [2:0] sz;
    logic [5:0] off;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    `CHK(&ctl, 1'b1)
    `CHK(rsp[PORT_NVM].readyout, 1'b1)
    `CHK(rsp[PORT_RAM].resp, RESP_OKAY)
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      run(i[4] ? PORT_RAM : PORT_NVM, 1'b1, SIZE_WORD, {i[3:0], 2'h0});
    end
    $display("test fill done");
    for (int i = 0; i < 24; i++) begin
      sz = 3'(i / 8);
      off = {4'(i / 3), 2'(i % 4)} & ~{4'h0, sz[1], sz != SIZE_BYTE};
      run(PORT_RAM, i[0], sz, off);
    end
    $display("test lanes done");
    for (int i = 0; i < 80; i++) begin
      @(posedge clk);
      alias_sel <= 1'($random(seed));
      p = {$random(seed)} % PORTS;
      sz = 3'({$random(seed)} % 3);
      off = 6'($random(seed)) & ~{4'h0, sz[1], sz != SIZE_BYTE};
      run(p, 1'($random(seed)), sz, off);
    end
    $display("test random done");
    print_verdict();
  end
endmodule : ahb_sram_flash_memory_controller_tb
